/* File: include/rlc_regs.svh */
// register offsets, field positions and reset values for the rotate datapath
`ifndef RLC_REGS_SVH
`define RLC_REGS_SVH

`define RLC_OFS_INSTR 8'h00
`define RLC_OFS_WREG 8'h04
`define RLC_OFS_STATUS 8'h08
`define RLC_OFS_BANK 8'h0c
`define RLC_OFS_TOS 8'h10
`define RLC_OFS_PC 8'h14
`define RLC_OFS_SHADOW 8'h18
`define RLC_OFS_MADDR 8'h1c
`define RLC_OFS_MDATA 8'h20
`define RLC_OFS_STATE 8'h24

`define RLC_ST_C 0
`define RLC_ST_DC 1
`define RLC_ST_Z 2
`define RLC_ST_OV 3
`define RLC_ST_N 4

`define RLC_OPC_ROT 6'h0d
`define RLC_OPC_RET 15'h0009
`define RLC_BIT_D 9
`define RLC_BIT_A 8
`define RLC_BIT_S 0

`define RLC_ACC_SPLIT 8'h80
`define RLC_ACC_LO_BANK 4'h0
`define RLC_ACC_HI_BANK 4'hf

`define RLC_RST_W 8'h00
`define RLC_RST_STATUS 5'h00
`define RLC_RST_BANK 4'h0
`define RLC_RST_INSTR 16'h0000

`endif

/* File: include/rlc_pkg.sv */
// types shared by the rotate datapath
package rlc_pkg;
   typedef enum logic [3:0] {
      st_idle = 4'b0000,
      st_q1 = 4'b0001,
      st_q2 = 4'b0010,
      st_q3 = 4'b0011,
      st_q4 = 4'b0100,
      st_n1 = 4'b0101,
      st_n2 = 4'b0110,
      st_n3 = 4'b0111,
      st_n4 = 4'b1000
   } rlc_state_t;
endpackage

/* File: src/rlc_rotate_alu.sv */
// rotate-left-through-carry arithmetic with flag outputs
`timescale 1ns/10ps
module rlc_rotate_alu #(
   parameter int DW = 8
) (
   input wire logic [DW-1:0] opnd,
   input wire logic cin,
   output logic [DW-1:0] res,
   output logic cout,
   output logic neg,
   output logic zero
);
   always_comb begin
      res = {opnd[DW-2:0], cin};
      cout = opnd[DW-1];
      neg = res[DW-1];
      zero = (res == '0);
   end
endmodule

/* File: src/rlc_file_mem.sv */
// banked file register memory, one write port and two read ports
`timescale 1ns/10ps
module rlc_file_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr_a,
   output logic [DW-1:0] rdata_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [DW-1:0] rdata_b
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // array holds no reset: contents are data, not control
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_comb begin
      rdata_a = mem[raddr_a];
      rdata_b = mem[raddr_b];
   end
endmodule

/* File: src/rlc_exec_top.sv */
// rotate-through-carry and return execution datapath with apb access
//
// Overview of operation
// - rotate operand left; old bit 7 to carry, old carry to bit 0
// - destination bit 0: result to working accumulator, file register untouched
// - destination bit 1: result written back to the source file register
// - access bit 0: operand from access bank, bank select register ignored
// - access bit 1: address is bank select register joined with file field
// - carry, negative and zero flags updated; other status flags kept
// - top six bits 001101 decode as rotate; d bit 9, a bit 8
// - return loads program counter from stack top in fourth phase; then nop cycle
// - return with shadow bit set restores accumulator, status, bank select
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "rlc_regs.svh"
module rlc_exec_top
   import rlc_pkg::*;
#(
   parameter int PC_W = 21,
   parameter int BANK_W = 4,
   parameter int FILE_W = 8
) (
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   localparam int AW = BANK_W + FILE_W;
   localparam int SW = 5;

   rlc_state_t state_r, state_nxt;
   logic [15:0] instr_r, instr_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic [FILE_W-1:0] opnd_r, opnd_nxt;
   logic [FILE_W-1:0] res_r, res_nxt;
   logic cout_r, cout_nxt;
   logic neg_r, neg_nxt;
   logic zero_r, zero_nxt;
   logic [FILE_W-1:0] w_r, w_nxt;
   logic [SW-1:0] status_r, status_nxt;
   logic [BANK_W-1:0] bank_select_register_r, bank_select_register_nxt;
   logic [PC_W-1:0] top_of_return_stack_r, top_of_return_stack_nxt;
   logic [PC_W-1:0] pc_r, pc_nxt;
   logic [FILE_W-1:0] shadow_w_r, shadow_w_nxt;
   logic [SW-1:0] shadow_status_r, shadow_status_nxt;
   logic [BANK_W-1:0] shadow_bank_r, shadow_bank_nxt;
   logic [AW-1:0] mem_addr_r, mem_addr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;

   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic [FILE_W-1:0] mem_wdata;
   logic [FILE_W-1:0] mem_rdata;
   logic [FILE_W-1:0] mem_rdata_b;
   logic [FILE_W-1:0] alu_res;
   logic alu_cout;
   logic alu_neg;
   logic alu_zero;
   logic is_rot;
   logic is_ret;
   logic busy;
   logic acc_phase;
   logic done;
   logic [FILE_W-1:0] ffield;

   assign is_rot = (instr_r[15:10] == `RLC_OPC_ROT);
   assign is_ret = (instr_r[15:1] == `RLC_OPC_RET);
   assign busy = (state_r != st_idle);
   assign ffield = instr_r[FILE_W-1:0];

   rlc_file_mem #(
      .AW(AW),
      .DW(FILE_W)
   ) u_mem (
      .clk(SYS_CLK),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr_a(addr_r),
      .rdata_a(mem_rdata),
      .raddr_b(mem_addr_r),
      .rdata_b(mem_rdata_b)
   );

   rlc_rotate_alu #(
      .DW(FILE_W)
   ) u_alu (
      .opnd(opnd_r),
      .cin(status_r[`RLC_ST_C]),
      .res(alu_res),
      .cout(alu_cout),
      .neg(alu_neg),
      .zero(alu_zero)
   );

   always_comb begin
      state_nxt = state_r;
      instr_nxt = instr_r;
      addr_nxt = addr_r;
      opnd_nxt = opnd_r;
      res_nxt = res_r;
      cout_nxt = cout_r;
      neg_nxt = neg_r;
      zero_nxt = zero_r;
      w_nxt = w_r;
      status_nxt = status_r;
      bank_select_register_nxt = bank_select_register_r;
      top_of_return_stack_nxt = top_of_return_stack_r;
      pc_nxt = pc_r;
      shadow_w_nxt = shadow_w_r;
      shadow_status_nxt = shadow_status_r;
      shadow_bank_nxt = shadow_bank_r;
      mem_addr_nxt = mem_addr_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      mem_we = 1'b0;
      mem_waddr = addr_r;
      mem_wdata = res_r;
      acc_phase = PSEL & PENABLE;
      // writes wait while an instruction runs so software never races the datapath
      pready_nxt = acc_phase & ~pready_r & ~(PWRITE & busy);
      done = acc_phase & pready_r;
      if (pready_nxt) begin
         pslverr_nxt = 1'b0;
         prdata_nxt = 32'h0000_0000;
         case (PADDR)
            `RLC_OFS_INSTR: prdata_nxt = {16'h0000, instr_r};
            `RLC_OFS_WREG: prdata_nxt = {24'h00_0000, w_r};
            `RLC_OFS_STATUS: prdata_nxt = {27'h000_0000, status_r};
            `RLC_OFS_BANK: prdata_nxt = {28'h000_0000, bank_select_register_r};
            `RLC_OFS_TOS: prdata_nxt = {11'h000, top_of_return_stack_r};
            `RLC_OFS_PC: prdata_nxt = {11'h000, pc_r};
            `RLC_OFS_SHADOW: begin
               prdata_nxt = {12'h000, shadow_bank_r, 3'h0, shadow_status_r, shadow_w_r};
            end
            `RLC_OFS_MADDR: prdata_nxt = {20'h0_0000, mem_addr_r};
            `RLC_OFS_MDATA: prdata_nxt = {24'h00_0000, mem_rdata_b};
            `RLC_OFS_STATE: prdata_nxt = {23'h00_0000, busy, 4'h0, state_r};
            default: pslverr_nxt = 1'b1;
         endcase
      end
      if (done & PWRITE & ~pslverr_r) begin
         case (PADDR)
            `RLC_OFS_INSTR: begin
               instr_nxt = PWDATA[15:0];
               state_nxt = st_q1;
            end
            `RLC_OFS_WREG: w_nxt = PWDATA[FILE_W-1:0];
            `RLC_OFS_STATUS: status_nxt = PWDATA[SW-1:0];
            `RLC_OFS_BANK: bank_select_register_nxt = PWDATA[BANK_W-1:0];
            `RLC_OFS_TOS: top_of_return_stack_nxt = PWDATA[PC_W-1:0];
            `RLC_OFS_PC: pc_nxt = PWDATA[PC_W-1:0];
            `RLC_OFS_SHADOW: begin
               shadow_w_nxt = PWDATA[7:0];
               shadow_status_nxt = PWDATA[12:8];
               shadow_bank_nxt = PWDATA[19:16];
            end
            `RLC_OFS_MADDR: mem_addr_nxt = PWDATA[AW-1:0];
            `RLC_OFS_MDATA: begin
               mem_we = 1'b1;
               mem_waddr = mem_addr_r;
               mem_wdata = PWDATA[FILE_W-1:0];
            end
            default: begin
            end
         endcase
      end
      case (state_r)
         st_q1: begin
            if (!instr_r[`RLC_BIT_A]) begin
               addr_nxt = (ffield < `RLC_ACC_SPLIT) ? {`RLC_ACC_LO_BANK, ffield}
                                                    : {`RLC_ACC_HI_BANK, ffield};
            end else begin
               addr_nxt = {bank_select_register_r, ffield};
            end
            state_nxt = st_q2;
         end
         st_q2: begin
            opnd_nxt = mem_rdata;
            state_nxt = st_q3;
         end
         st_q3: begin
            res_nxt = alu_res;
            cout_nxt = alu_cout;
            neg_nxt = alu_neg;
            zero_nxt = alu_zero;
            state_nxt = st_q4;
         end
         st_q4: begin
            if (is_rot) begin
               if (instr_r[`RLC_BIT_D]) begin
                  mem_we = 1'b1;
                  mem_waddr = addr_r;
                  mem_wdata = res_r;
               end else begin
                  w_nxt = res_r;
               end
               status_nxt[`RLC_ST_C] = cout_r;
               status_nxt[`RLC_ST_N] = neg_r;
               status_nxt[`RLC_ST_Z] = zero_r;
            end
            if (is_ret) begin
               pc_nxt = top_of_return_stack_r;
               if (instr_r[`RLC_BIT_S]) begin
                  w_nxt = shadow_w_r;
                  status_nxt = shadow_status_r;
                  bank_select_register_nxt = shadow_bank_r;
               end
            end
            state_nxt = is_ret ? st_n1 : st_idle;
         end
         st_n1: state_nxt = st_n2;
         st_n2: state_nxt = st_n3;
         st_n3: state_nxt = st_n4;
         st_n4: state_nxt = st_idle;
         default: begin
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= st_idle;
         instr_r <= `RLC_RST_INSTR;
         addr_r <= '0;
         opnd_r <= '0;
         res_r <= '0;
         cout_r <= 1'b0;
         neg_r <= 1'b0;
         zero_r <= 1'b0;
         w_r <= `RLC_RST_W;
         status_r <= `RLC_RST_STATUS;
         bank_select_register_r <= `RLC_RST_BANK;
         top_of_return_stack_r <= '0;
         pc_r <= '0;
         shadow_w_r <= `RLC_RST_W;
         shadow_status_r <= `RLC_RST_STATUS;
         shadow_bank_r <= `RLC_RST_BANK;
         mem_addr_r <= '0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         instr_r <= instr_nxt;
         addr_r <= addr_nxt;
         opnd_r <= opnd_nxt;
         res_r <= res_nxt;
         cout_r <= cout_nxt;
         neg_r <= neg_nxt;
         zero_r <= zero_nxt;
         w_r <= w_nxt;
         status_r <= status_nxt;
         bank_select_register_r <= bank_select_register_nxt;
         top_of_return_stack_r <= top_of_return_stack_nxt;
         pc_r <= pc_nxt;
         shadow_w_r <= shadow_w_nxt;
         shadow_status_r <= shadow_status_nxt;
         shadow_bank_r <= shadow_bank_nxt;
         mem_addr_r <= mem_addr_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;

   // helper terms read only by the checks below
   logic [FILE_W-1:0] rot_ref;
   logic opnd_msb;
   logic res_msb;
   logic [1:0] keep_bits;
   assign rot_ref = {opnd_r[FILE_W-2:0], status_r[`RLC_ST_C]};
   assign opnd_msb = opnd_r[FILE_W-1];
   assign res_msb = res_r[FILE_W-1];
   assign keep_bits = {status_r[`RLC_ST_OV], status_r[`RLC_ST_DC]};

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_exec_cycle;
      state_r == st_q1 ##1 state_r == st_q2 ##1 state_r == st_q3 ##1 state_r == st_q4;
   endsequence

   sequence s_nop_cycle;
      state_r == st_n1 ##1 state_r == st_n2 ##1 state_r == st_n3 ##1 state_r == st_n4
         ##1 state_r == st_idle;
   endsequence

   a_phase_order: assert property (
      (state_r == st_idle && state_nxt == st_q1) |=> s_exec_cycle ##1 state_r != st_q1)
      else $error("instruction phases out of order");

   a_rot_result: assert property (
      (state_r == st_q3 && is_rot) |=> res_r == $past(rot_ref))
      else $error("rotate result wrong");

   a_carry_out: assert property (
      (state_r == st_q3 && is_rot) |-> ##2 status_r[`RLC_ST_C] == $past(opnd_msb, 2))
      else $error("carry not taken from old bit 7");

   a_dest_accum: assert property (
      (state_r == st_q4 && is_rot && !instr_r[`RLC_BIT_D]) |-> !mem_we
         ##1 w_r == $past(res_r))
      else $error("accumulator destination wrong");

   a_dest_file: assert property (
      (state_r == st_q4 && is_rot && instr_r[`RLC_BIT_D]) |=>
         mem_rdata == $past(res_r) && w_r == $past(w_r))
      else $error("file destination wrong");

   a_access_bank: assert property (
      (state_r == st_q2 && !instr_r[`RLC_BIT_A]) |->
         addr_r[AW-1:FILE_W] == (ffield[FILE_W-1] ? `RLC_ACC_HI_BANK : `RLC_ACC_LO_BANK))
      else $error("access bank address wrong");

   a_bank_select: assert property (
      (state_r == st_q2 && instr_r[`RLC_BIT_A]) |-> addr_r == {bank_select_register_r, ffield})
      else $error("banked address wrong");

   a_flag_update: assert property (
      (state_r == st_q4 && is_rot) |=> status_r[`RLC_ST_Z] == ($past(res_r) == '0)
         && status_r[`RLC_ST_N] == $past(res_msb) && keep_bits == $past(keep_bits))
      else $error("status flags wrong");

   a_decode_rot: assert property (
      (state_r == st_q1 && is_rot && instr_r[`RLC_BIT_D]) |-> ##3
         (mem_we && mem_waddr[FILE_W-1:0] == ffield))
      else $error("rotate not decoded");

   a_ret_pop: assert property (
      (state_r == st_q4 && is_ret) |=> pc_r == $past(top_of_return_stack_r) ##0 s_nop_cycle)
      else $error("return pop or nop cycle wrong");

   a_ret_shadow: assert property (
      (state_r == st_q4 && is_ret && instr_r[`RLC_BIT_S]) |=> w_r == $past(shadow_w_r)
         && status_r == $past(shadow_status_r) && bank_select_register_r == $past(shadow_bank_r))
      else $error("shadow restore missing");

   a_ret_plain: assert property (
      (state_r == st_q4 && is_ret && !instr_r[`RLC_BIT_S]) |=> w_r == $past(w_r)
         && status_r == $past(status_r) && bank_select_register_r == $past(bank_select_register_r))
      else $error("plain return changed registers");

   a_ready_pulse: assert property (
      PREADY |=> !PREADY)
      else $error("ready held more than one cycle");
endmodule

/* File: dv/rlc_core_model.sv */
// behavioural mirror of the core registers and data file
`timescale 1ns/10ps
module rlc_core_model;
   logic [7:0] w = 8'h00;
   logic [4:0] st = 5'h00;
   logic [3:0] bank = 4'h0;
   logic [20:0] pc = 21'h0;
   logic [7:0] mem [4096];
   function automatic logic [11:0] op_addr(input logic a, input logic [7:0] f);
      if (a) begin
         return {bank, f};
      end
      return {(f < 8'h80) ? 4'h0 : 4'hf, f};
   endfunction
   // anything not decoded as rotate or return behaves as a nop
   task automatic do_instr(input logic [15:0] ins, input logic [20:0] top_of_return_stack);
      logic [11:0] ad;
      logic [7:0] r;
      ad = op_addr(ins[8], ins[7:0]);
      if (ins[15:10] == 6'h0d) begin
         r = {mem[ad][6:0], st[0]};
         st = {r[7], st[3], r == 8'h00, st[1], mem[ad][7]};
         if (ins[9]) begin
            mem[ad] = r;
         end else begin
            w = r;
         end
      end else if (ins[15:1] == 15'h0009) begin
         pc = top_of_return_stack;
      end
   endtask
   task automatic restore(input logic [19:0] shd);
      w = shd[7:0];
      st = shd[12:8];
      bank = shd[19:16];
   endtask
endmodule

/* File: dv/rlc_exec_top_bench.sv */
// self-checking bench for the rotate and return datapath
`timescale 1ns/10ps
`include "rlc_regs.svh"
module rlc_exec_top_bench;
   logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int bad_count = 0;
   int num_checks = 0;
   int exp_wait = 2;
   rlc_core_model MDL();
   rlc_exec_top DUT(.SYS_CLK(sys_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish;
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // holds the request until pready is sampled high; writes stall while busy
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pready", {31'h0, pready}, 32'h1);
      check("pready_wait", 32'(n), 32'(exp_wait));
   endtask
   task automatic rdchk(input string name, input logic [7:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      check(name, rd, exp);
      check("pslverr", {31'h0, err}, {31'h0, ad > `RLC_OFS_STATE});
   endtask
   // launch, confirm busy on the first look, then poll until idle
   task automatic run(input logic [15:0] ins);
      int k;
      k = 0;
      apb(1'b1, `RLC_OFS_INSTR, 32'(ins));
      apb(1'b0, `RLC_OFS_STATE, 32'h0);
      check("busy", rd, 32'h0000_0103);
      do begin
         apb(1'b0, `RLC_OFS_STATE, 32'h0);
         k++;
      end while (rd[8] !== 1'b0 && k < 20);
      check("idle", rd, 32'h0);
   endtask
   initial begin
      #40000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      int i;
      logic [7:0] f, opnd;
      logic d, a;
      logic [11:0] ad;
      logic [15:0] ins;
      logic [20:0] top_of_return_stack;
      logic [19:0] shd;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(32'hfb8e));
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      rdchk("w_rst", `RLC_OFS_WREG, 32'h0);
      rdchk("status_rst", `RLC_OFS_STATUS, 32'h0);
      rdchk("state_rst", `RLC_OFS_STATE, 32'h0);
      rdchk("unmapped", 8'h40, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      for (i = 0; i < 24; i++) begin
         f = 8'($urandom);
         d = 1'($urandom);
         a = 1'($urandom);
         opnd = 8'($urandom);
         MDL.st = 5'($urandom);
         MDL.bank = 4'($urandom);
         MDL.w = 8'($urandom);
         // access split edges: zero result with carry out, and all ones
         if (i < 2) begin
            f = (i == 0) ? 8'h7f : 8'h80;
            a = 1'b0;
            opnd = (i == 0) ? 8'h80 : 8'h7f;
            MDL.st[0] = 1'(i);
         end
         ad = MDL.op_addr(a, f);
         MDL.mem[ad] = opnd;
         apb(1'b1, `RLC_OFS_STATUS, 32'(MDL.st));
         apb(1'b1, `RLC_OFS_BANK, 32'(MDL.bank));
         apb(1'b1, `RLC_OFS_WREG, 32'(MDL.w));
         apb(1'b1, `RLC_OFS_MADDR, 32'(ad));
         apb(1'b1, `RLC_OFS_MDATA, 32'(opnd));
         ins = {(i % 6 == 5) ? 6'h0c : 6'h0d, d, a, f};
         run(ins);
         MDL.do_instr(ins, 21'h0);
         rdchk("w", `RLC_OFS_WREG, 32'(MDL.w));
         rdchk("status", `RLC_OFS_STATUS, 32'(MDL.st));
         apb(1'b1, `RLC_OFS_MADDR, 32'(ad));
         rdchk("mem", `RLC_OFS_MDATA, 32'(MDL.mem[ad]));
      end
      for (i = 0; i < 4; i++) begin
         top_of_return_stack = 21'($urandom);
         shd = 20'($urandom) & 20'hf1fff;
         apb(1'b1, `RLC_OFS_TOS, 32'(top_of_return_stack));
         apb(1'b1, `RLC_OFS_SHADOW, 32'(shd));
         ins = 16'h0012 | 16'(i % 2);
         run(ins);
         MDL.do_instr(ins, top_of_return_stack);
         if (i % 2 == 1) begin
            MDL.restore(shd);
         end
         rdchk("pc", `RLC_OFS_PC, 32'(MDL.pc));
         rdchk("w_ret", `RLC_OFS_WREG, 32'(MDL.w));
         rdchk("status_ret", `RLC_OFS_STATUS, 32'(MDL.st));
         rdchk("bank_ret", `RLC_OFS_BANK, 32'(MDL.bank));
      end
      // a write issued while a return runs stalls until its nop cycle ends
      apb(1'b1, `RLC_OFS_INSTR, 32'h0000_0012);
      exp_wait = 8;
      apb(1'b1, `RLC_OFS_WREG, 32'h0000_005a);
      exp_wait = 2;
      MDL.do_instr(16'h0012, top_of_return_stack);
      MDL.w = 8'h5a;
      rdchk("w_stall", `RLC_OFS_WREG, 32'(MDL.w));
      rdchk("pc_stall", `RLC_OFS_PC, 32'(MDL.pc));
      tally_and_finish();
   end
endmodule
